// File: core/otp_sec_pkg.sv
// Purpose: Shared constants for the tile OTP and security configuration block
// Assumes: 32-bit AXI4-Lite register bus, 25 MHz system clock
// Notes:   Offsets are byte addresses of aligned words
package otp_sec_pkg;
   localparam int          ROW_W          = 32;
   localparam int          ROWS_PER_SECT  = 512;
   localparam int          SECT_N         = 4;
   localparam int          ADDR_W         = 11;
   localparam int          DEPTH          = SECT_N * ROWS_PER_SECT;
   // Row holding the security word; boot image follows from row 0
   localparam logic [10:0] SEC_ROW        = 11'h7FF;
   localparam logic [10:0] BOOT_FIRST_ROW = 11'h000;
   // Security bit positions
   localparam int          B_NO_DBG       = 0;
   localparam int          B_NO_LINK      = 1;
   localparam int          B_SEC_BOOT     = 5;
   localparam int          B_REDUND       = 7;
   localparam int          B_LOCK0        = 8;
   localparam int          B_MLOCK        = 12;
   localparam int          B_NO_DBG_OTP   = 13;
   localparam int          B_NO_SYNC      = 14;
   localparam int          B_GP_LO        = 15;
   localparam int          B_UID_LO       = 22;
   // Register offsets
   localparam logic [7:0]  OFS_SEC        = 8'h00;
   localparam logic [7:0]  OFS_ADDR       = 8'h04;
   localparam logic [7:0]  OFS_DATA       = 8'h08;
   localparam logic [7:0]  OFS_CTRL       = 8'h0C;
   localparam logic [7:0]  OFS_STAT       = 8'h10;
   localparam logic [7:0]  OFS_RDATA      = 8'h14;
   // Control port bits
   localparam int          C_PROG         = 0;
   localparam int          C_READ         = 1;
   localparam int          C_PROG_SEC     = 2;
   // Resource identifiers of the three programming ports
   localparam logic [23:0] RID_ADDR       = 24'h100200;
   localparam logic [23:0] RID_DATA       = 24'h200100;
   localparam logic [23:0] RID_CTRL       = 24'h100300;
   localparam logic [1:0]  RESP_OK        = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;
   localparam logic [1:0]  RESP_DECERR    = 2'h3;
endpackage : otp_sec_pkg

// File: core/otp_array.sv
// Purpose: OTP cell array, one read or one-way program per cycle
// Assumes: Cells start blank (all zero)
// Notes:   Read data comes out of a register
`timescale 1ns/1ps
module otp_array (
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        rd_in,
   input  wire logic        wr_in,
   input  wire logic [10:0] addr_in,
   input  wire logic [31:0] wdata_in,
   output logic      [31:0] rdata_out
);
   logic [31:0] mem_q [otp_sec_pkg::DEPTH];

   always_ff @(posedge clk_in) begin
      if (wr_in) begin
         // Cells only ever go from zero to one
         mem_q[addr_in] <= mem_q[addr_in] | wdata_in;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_out <= 32'h0000_0000;
      end else if (rd_in) begin
         rdata_out <= mem_q[addr_in];
      end
   end

   initial begin
      for (int i = 0; i < otp_sec_pkg::DEPTH; i++) begin
         mem_q[i] = 32'h0000_0000;
      end
   end
endmodule : otp_array

// File: core/otp_security_config.sv
// Contract
// - Security bit 0 blocks debug-port access to tile state and memory.
// - Security bit 1 refuses other tiles' switch access to processor state.
// - Security bit 5 forces boot from OTP address 0.
// - Security bit 7 enables OTP redundant rows.
// - Bits 8..11 lock programming of sectors 0..3; reads still allowed.
// - Bit 12 rejects all programming, sectors and security word.
// - Bit 13 denies debug-port read and write of this OTP.
// - Bit 14 disables debug sync pin as output and input.
// - Bits 15..21 software-readable user bits; 22..31 user-code extension.
// - OTP is four sectors of 512 rows, 32 bits each.
// - Security word loads from OTP at power-up before enforcement.
// - Remaining OTP is copied to SRAM and run first.
// - Programming uses address, data and control ports with fixed identifiers.
// - Each tile has 8 KB OTP plus its own security register.
// - Debug user code carries bits 22..31 of security word, zero if blank.
//
// Purpose: Tile OTP with security configuration, AXI4-Lite programming ports
// Assumes: Outside logic honours the gate outputs; SRAM takes one word per strobe
// Notes:   Enforcement outputs stay in their safe state until the load completes
`timescale 1ns/1ps
module otp_security_config (
   input  wire logic        clk_sys_in,
   input  wire logic        nrst_in,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        dbg_req_in,
   input  wire logic        dbg_otp_rd_in,
   input  wire logic [10:0] dbg_otp_addr_in,
   output logic             dbg_grant_out,
   output logic [31:0]      dbg_otp_rdata_out,
   output logic             dbg_otp_valid_out,
   output logic [9:0]       dbg_user_id_out,
   input  wire logic        link_req_in,
   output logic             link_grant_out,
   output logic             boot_from_otp_out,
   output logic             redundant_rows_out,
   input  wire logic        sync_pin_in,
   input  wire logic        sync_brk_in,
   output logic             sync_pin_out,
   output logic             sync_pin_oe_out,
   output logic             sync_debug_enter_out,
   output logic             sram_wr_out,
   output logic [10:0]      sram_addr_out,
   output logic [31:0]      sram_wdata_out,
   output logic             boot_done_out
);
   typedef enum logic [2:0] {
      ST_RST   = 3'h0,
      ST_LDSEC = 3'h1,
      ST_LDWT  = 3'h2,
      ST_COPY  = 3'h3,
      ST_CPWT  = 3'h4,
      ST_RUN   = 3'h5,
      ST_PROG  = 3'h6,
      ST_RDWT  = 3'h7
   } state_t;

   logic [1:0]  rst_sync_q;
   logic        rst_n;
   state_t      state_q;
   logic [31:0] sec_q;
   logic [10:0] row_q;
   logic [15:0] prog_addr_q;
   logic [31:0] prog_data_q;
   logic [15:0] prog_ctrl_q;
   logic [31:0] rd_data_q;
   logic        err_q;
   logic        loaded_q;
   logic        arr_rd;
   logic        arr_wr;
   logic [10:0] arr_addr;
   logic [31:0] arr_wdata;
   logic [31:0] arr_rdata;
   logic        dbg_rd_q;
   logic [2:0]  sync_q;
   logic        sync_level_q;
   logic [7:0]  aw_addr_q;
   logic        aw_have_q;
   logic [31:0] w_data_q;
   logic [3:0]  w_strb_q;
   logic        w_have_q;
   logic        prog_req;
   logic        prog_ok;
   logic        sect_lock;
   logic        cpu_rd_req;
   logic        dbg_rd_ok;
   logic        wr_fire;
   logic        prog_sec_q;
   logic        boot_done_q;
   logic        busy;
   logic [31:0] rd_mux;
   logic [1:0]  rd_resp;

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // AXI write path: address and data taken in either order
   assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
   assign wr_fire       = aw_have_q && w_have_q && !s_axi_bvalid;

   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         aw_have_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_have_q  <= 1'b0;
         w_data_q  <= 32'h0000_0000;
         w_strb_q  <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_have_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_have_q <= 1'b0;
         end
      end
   end

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // Address and data ports of the programmer, and the write response for every offset
   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         prog_addr_q <= 16'h0000;
         prog_data_q <= 32'h0000_0000;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else begin
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= otp_sec_pkg::RESP_OK;
            case (aw_addr_q)
               otp_sec_pkg::OFS_ADDR: begin
                  prog_addr_q <= 16'(merge({16'h0000, prog_addr_q}, w_data_q, w_strb_q));
               end
               otp_sec_pkg::OFS_DATA: begin
                  prog_data_q <= merge(prog_data_q, w_data_q, w_strb_q);
               end
               otp_sec_pkg::OFS_CTRL, otp_sec_pkg::OFS_SEC,
               otp_sec_pkg::OFS_STAT, otp_sec_pkg::OFS_RDATA: begin
               end
               default: begin
                  s_axi_bresp <= otp_sec_pkg::RESP_DECERR;
               end
            endcase
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Control strobe: command bits self-clear once the engine accepts them
   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         prog_ctrl_q <= 16'h0000;
      end else if (wr_fire && aw_addr_q == otp_sec_pkg::OFS_CTRL && w_strb_q[0]) begin
         prog_ctrl_q <= w_data_q[15:0];
      end else if (state_q == ST_RUN && !dbg_rd_ok) begin
         prog_ctrl_q <= 16'h0000;
      end
   end

   assign prog_req   = prog_ctrl_q[otp_sec_pkg::C_PROG] || prog_ctrl_q[otp_sec_pkg::C_PROG_SEC];
   assign cpu_rd_req = prog_ctrl_q[otp_sec_pkg::C_READ];
   assign sect_lock  = sec_q[otp_sec_pkg::B_LOCK0 + 32'(prog_addr_q[10:9])];
   assign prog_ok    = !sec_q[otp_sec_pkg::B_MLOCK]
                       && (prog_ctrl_q[otp_sec_pkg::C_PROG_SEC] || !sect_lock);
   assign dbg_rd_ok  = dbg_otp_rd_in && boot_done_q && !sec_q[otp_sec_pkg::B_NO_DBG_OTP];
   assign busy       = prog_req || cpu_rd_req || state_q != ST_RUN;

   // Array port: one owner per cycle, debug first in ST_RUN, so load, copy, debug and software never collide
   always_comb begin
      arr_rd    = 1'b0;
      arr_wr    = 1'b0;
      arr_addr  = row_q;
      arr_wdata = prog_data_q;
      case (state_q)
         ST_LDSEC: begin
            arr_rd   = 1'b1;
            arr_addr = otp_sec_pkg::SEC_ROW;
         end
         ST_COPY: begin
            arr_rd = 1'b1;
         end
         ST_RUN: begin
            if (dbg_rd_ok) begin
               arr_rd   = 1'b1;
               arr_addr = dbg_otp_addr_in;
            end else if (!prog_req && cpu_rd_req) begin
               arr_rd   = 1'b1;
               arr_addr = prog_addr_q[10:0];
            end
         end
         ST_PROG: begin
            arr_wr   = !err_q;
            arr_addr = prog_sec_q ? otp_sec_pkg::SEC_ROW : prog_addr_q[10:0];
         end
         default: begin
         end
      endcase
   end

   otp_array i_otp_array (
      .clk_in    (clk_sys_in),
      .rst_n_in  (rst_n),
      .rd_in     (arr_rd),
      .wr_in     (arr_wr),
      .addr_in   (arr_addr),
      .wdata_in  (arr_wdata),
      .rdata_out (arr_rdata)
   );

   // AXI read path: one read in flight, data registered at address accept
   assign s_axi_arready = !s_axi_rvalid;
   always_comb begin
      rd_mux  = 32'h0000_0000;
      rd_resp = otp_sec_pkg::RESP_OK;
      case (s_axi_araddr)
         otp_sec_pkg::OFS_SEC:   rd_mux = sec_q;
         otp_sec_pkg::OFS_ADDR:  rd_mux = {16'h0000, prog_addr_q};
         otp_sec_pkg::OFS_DATA:  rd_mux = prog_data_q;
         otp_sec_pkg::OFS_CTRL:  rd_mux = {16'h0000, prog_ctrl_q};
         otp_sec_pkg::OFS_STAT:  rd_mux = {30'h0000_0000, err_q, busy};
         otp_sec_pkg::OFS_RDATA: rd_mux = rd_data_q;
         default:                rd_resp = otp_sec_pkg::RESP_DECERR;
      endcase
   end

   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_mux;
         s_axi_rresp  <= rd_resp;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Boot completion, SRAM copy strobe and debug read return
   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         boot_done_q       <= 1'b0;
         sram_wr_out       <= 1'b0;
         sram_addr_out     <= 11'h000;
         sram_wdata_out    <= 32'h0000_0000;
         dbg_otp_valid_out <= 1'b0;
         dbg_otp_rdata_out <= 32'h0000_0000;
      end else begin
         // Set one cycle after the last copy so no SRAM write overlaps it
         if (state_q == ST_RUN) begin
            boot_done_q <= 1'b1;
         end
         sram_wr_out       <= state_q == ST_CPWT;
         sram_addr_out     <= row_q;
         sram_wdata_out    <= arr_rdata;
         dbg_otp_valid_out <= dbg_rd_q;
         if (dbg_rd_q) begin
            dbg_otp_rdata_out <= arr_rdata;
         end
      end
   end
   assign boot_done_out      = boot_done_q;
   assign dbg_grant_out      = boot_done_q && dbg_req_in && !sec_q[otp_sec_pkg::B_NO_DBG];
   assign link_grant_out     = boot_done_q && link_req_in && !sec_q[otp_sec_pkg::B_NO_LINK];
   assign boot_from_otp_out  = loaded_q && sec_q[otp_sec_pkg::B_SEC_BOOT];
   assign redundant_rows_out = loaded_q && sec_q[otp_sec_pkg::B_REDUND];
   assign dbg_user_id_out    = sec_q[31:otp_sec_pkg::B_UID_LO];

   // Shared sync line: three stages, level moves once the last two agree
   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         sync_q               <= 3'h7;
         sync_level_q         <= 1'b1;
         sync_pin_oe_out      <= 1'b0;
         sync_debug_enter_out <= 1'b0;
      end else begin
         sync_q <= {sync_q[1:0], sync_pin_in};
         if (sync_q[2] == sync_q[1]) begin
            sync_level_q <= sync_q[1];
         end
         sync_pin_oe_out      <= boot_done_q && sync_brk_in && !sec_q[otp_sec_pkg::B_NO_SYNC];
         sync_debug_enter_out <= boot_done_q && !sync_level_q
                                 && !sec_q[otp_sec_pkg::B_NO_SYNC];
      end
   end
   // Open-drain: the line is only pulled low, its pull-up gives the high level
   assign sync_pin_out = 1'b0;

   // Load, copy and programming sequencer
   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         state_q  <= ST_RST;
         sec_q    <= 32'h0000_0000;
         row_q    <= 11'h000;
         loaded_q <= 1'b0;
         err_q    <= 1'b0;
         rd_data_q <= 32'h0000_0000;
         dbg_rd_q <= 1'b0;
         prog_sec_q <= 1'b0;
      end else begin
         dbg_rd_q <= 1'b0;
         case (state_q)
            ST_RST: begin
               state_q <= ST_LDSEC;
            end
            ST_LDSEC: begin
               state_q <= ST_LDWT;
            end
            ST_LDWT: begin
               sec_q    <= arr_rdata;
               loaded_q <= 1'b1;
               row_q    <= otp_sec_pkg::BOOT_FIRST_ROW;
               state_q  <= ST_COPY;
            end
            ST_COPY: begin
               state_q <= ST_CPWT;
            end
            ST_CPWT: begin
               if (row_q == otp_sec_pkg::SEC_ROW - 11'h001) begin
                  state_q <= ST_RUN;
               end else begin
                  row_q   <= row_q + 11'h001;
                  state_q <= ST_COPY;
               end
            end
            ST_RUN: begin
               if (dbg_rd_ok) begin
                  dbg_rd_q <= 1'b1;
               end else if (prog_req) begin
                  // Command bits clear on accept, so latch what the write needs
                  err_q      <= !prog_ok;
                  prog_sec_q <= prog_ctrl_q[otp_sec_pkg::C_PROG_SEC];
                  state_q    <= ST_PROG;
               end else if (cpu_rd_req) begin
                  state_q <= ST_RDWT;
               end
            end
            ST_PROG: begin
               if (prog_sec_q && !err_q) begin
                  sec_q <= sec_q | prog_data_q;
               end
               state_q <= ST_RUN;
            end
            ST_RDWT: begin
               rd_data_q <= arr_rdata;
               state_q   <= ST_RUN;
            end
            default: begin
               state_q <= ST_RST;
            end
         endcase
      end
   end
endmodule : otp_security_config

// File: verification/otp_sec_chk.sv
// Purpose: Port-level assertions for the OTP security block
// Assumes: Sees only the top module ports
// Notes:   Bound to every instance of the top module
`timescale 1ns/1ps
module otp_sec_chk (
   input  wire logic        clk_sys_in,
   input  wire logic        nrst_in,
   input  wire logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic        dbg_req_in,
   input  wire logic        dbg_grant_out,
   input  wire logic        link_req_in,
   input  wire logic        link_grant_out,
   input  wire logic        boot_done_out,
   input  wire logic        sram_wr_out,
   input  wire logic        sync_pin_out,
   input  wire logic        sync_pin_oe_out
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!nrst_in);
   chk_safe_before_load: assert property (!boot_done_out |-> !dbg_grant_out && !link_grant_out)
      else $error("grant given before security load");
   chk_dbg_grant_cause: assert property (dbg_grant_out |-> dbg_req_in)
      else $error("debug grant without request");
   chk_link_grant_cause: assert property (link_grant_out |-> link_req_in)
      else $error("link grant without request");
   chk_boot_done_sticky: assert property (boot_done_out |=> boot_done_out)
      else $error("boot done dropped");
   chk_sram_copy_early: assert property (sram_wr_out |-> !boot_done_out)
      else $error("sram write after boot done");
   chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response not held");
   chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   chk_sync_drive_low: assert property (sync_pin_oe_out |-> !sync_pin_out)
      else $error("sync pin driven high");
endmodule : otp_sec_chk

bind otp_security_config otp_sec_chk i_otp_sec_chk (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
   .dbg_req_in(dbg_req_in), .dbg_grant_out(dbg_grant_out), .link_req_in(link_req_in),
   .link_grant_out(link_grant_out), .boot_done_out(boot_done_out), .sram_wr_out(sram_wr_out),
   .sync_pin_out(sync_pin_out), .sync_pin_oe_out(sync_pin_oe_out));

// File: verification/dbg_host_model.sv
// Purpose: Debug port, other tile and shared sync line beside the block
// Assumes: Requests follow go_in one cycle later
// Notes:   Released address toggles so a stale value never looks valid
`timescale 1ns/1ps
module dbg_host_model (
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        go_in,
   input  wire logic        drive_in,
   input  wire logic        oe_in,
   output logic             dbg_req_out,
   output logic             dbg_rd_out,
   output logic [10:0]      dbg_addr_out,
   output logic             link_req_out,
   output logic             brk_out,
   output logic             sync_level_out
);
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         dbg_req_out  <= 1'b0;
         dbg_rd_out   <= 1'b0;
         dbg_addr_out <= 11'h000;
         link_req_out <= 1'b0;
         brk_out      <= 1'b0;
      end else begin
         dbg_req_out  <= go_in;
         dbg_rd_out   <= go_in;
         dbg_addr_out <= go_in ? 11'h005 : ~dbg_addr_out;
         link_req_out <= go_in;
         brk_out      <= go_in;
      end
   end
   // Pull-up holds the line high unless someone drives it
   assign sync_level_out = oe_in ? drive_in : 1'b1;
endmodule : dbg_host_model

// File: verification/tb.sv
// Purpose: Register-level test of the OTP security block
// Assumes: OTP contents survive a reset, as after a power cycle
// Notes:   Security bits take effect as soon as the security word is programmed
`timescale 1ns/1ps
module tb;
   logic clk_sys_in, nrst_in, go, awv, wv, bre, arv, rre;
   logic [7:0] awa, ara;
   logic [31:0] wd, rd, sv;
   logic [1:0] rs;
   logic awr, wr, bv, arr, rv, dq, drd, lq, brk, lvl, dg, dov, lg, bfo, rr, spo, spe, bd;
   logic [1:0] br, rrs;
   logic [31:0] rdt, dod;
   logic [10:0] da;
   logic [9:0] uid;
   int bad_count, n_checks, k;
   initial begin
      clk_sys_in = 1'b0;
      forever #20 clk_sys_in = ~clk_sys_in;
   end
   otp_security_config i_otp_security_config (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
      .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rrs), .s_axi_rvalid(rv),
      .s_axi_rready(rre), .dbg_req_in(dq), .dbg_otp_rd_in(drd), .dbg_otp_addr_in(da),
      .dbg_grant_out(dg), .dbg_otp_rdata_out(dod), .dbg_otp_valid_out(dov),
      .dbg_user_id_out(uid), .link_req_in(lq), .link_grant_out(lg), .boot_from_otp_out(bfo),
      .redundant_rows_out(rr), .sync_pin_in(lvl), .sync_brk_in(brk), .sync_pin_out(spo),
      .sync_pin_oe_out(spe), .sync_debug_enter_out(), .sram_wr_out(), .sram_addr_out(),
      .sram_wdata_out(), .boot_done_out(bd));
   dbg_host_model i_dbg_host_model (.clk_in(clk_sys_in), .rst_n_in(nrst_in), .go_in(go),
      .drive_in(spo), .oe_in(spe), .dbg_req_out(dq), .dbg_rd_out(drd), .dbg_addr_out(da),
      .link_req_out(lq), .brk_out(brk), .sync_level_out(lvl));
   task automatic close_out;
      $display("Checks %0d, mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : close_out
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task automatic hang;
      bad_count++;
      $display("Error at %0t: wait ran out", $time);
      close_out();
   endtask : hang
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
      for (k = 0; k < 200; k++) begin
         @(posedge clk_sys_in);
         if (awv && awr) awv <= 1'b0;
         if (wv && wr) wv <= 1'b0;
         if (bre && bv) begin bre <= 1'b0; break; end
      end
      if (k == 200) hang();
   endtask : axw
   task automatic axr(input logic [7:0] a);
      @(posedge clk_sys_in);
      ara <= a; arv <= 1'b1; rre <= 1'b1;
      for (k = 0; k < 200; k++) begin
         @(posedge clk_sys_in);
         if (arv && arr) arv <= 1'b0;
         if (rre && rv) begin rre <= 1'b0; rd = rdt; rs = rrs; break; end
      end
      if (k == 200) hang();
   endtask : axr
   task automatic boot;
      nrst_in <= 1'b0;
      repeat (10) @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      for (k = 0; k < 8000 && bd !== 1'b1; k++) @(posedge clk_sys_in);
      if (k == 8000) hang();
   endtask : boot
   task automatic op(input logic [10:0] row, input logic [31:0] d, input int c);
      axw(otp_sec_pkg::OFS_ADDR, {21'h0, row});
      axw(otp_sec_pkg::OFS_DATA, d);
      axw(otp_sec_pkg::OFS_CTRL, 32'h1 << c);
      for (int n = 0; n < 100; n++) begin
         axr(otp_sec_pkg::OFS_STAT);
         if (rd[0] === 1'b0) break;
      end
      if (rd[0] !== 1'b0) hang();
      if (c == otp_sec_pkg::C_READ) axr(otp_sec_pkg::OFS_RDATA);
   endtask : op
   task automatic probe(input logic en);
      go <= 1'b1;
      for (k = 0; k < 40 && dov !== 1'b1; k++) @(posedge clk_sys_in);
      go <= 1'b0;
      cmp({dg, lg, dov, spe}, {en, en, en, en});
      if (en) cmp(dod, 32'h0F00_00F0);
   endtask : probe
   initial begin
      {nrst_in, go, awv, wv, bre, arv, rre} = '0;
      {awa, ara, wd, bad_count, n_checks} = '0;
      sv = 32'hA940_61A3;
      boot();
      axr(otp_sec_pkg::OFS_SEC); cmp(rd, 32'h0);
      cmp({uid, bfo, rr}, 12'h0);
      op(11'h005, 32'h0000_00F0, otp_sec_pkg::C_PROG);
      op(11'h005, 32'h0F00_0000, otp_sec_pkg::C_PROG);
      op(11'h005, 32'h0, otp_sec_pkg::C_READ); cmp(rd, 32'h0F00_00F0);
      op(11'h258, 32'hA5A5_0000, otp_sec_pkg::C_PROG);
      op(11'h258, 32'h0, otp_sec_pkg::C_READ); cmp(rd, 32'hA5A5_0000);
      probe(1'b1);
      axr(8'hF0); cmp(rs, otp_sec_pkg::RESP_DECERR);
      $display("Test blank device done");
      op(11'h000, sv, otp_sec_pkg::C_PROG_SEC);
      boot();
      axr(otp_sec_pkg::OFS_SEC); cmp(rd, sv);
      cmp({uid, bfo, rr}, {10'h2A5, 2'h3});
      probe(1'b0);
      op(11'h003, 32'hFFFF_FFFF, otp_sec_pkg::C_PROG);
      op(11'h003, 32'h0, otp_sec_pkg::C_READ); cmp(rd, 32'h0);
      op(11'h258, 32'h0000_FFFF, otp_sec_pkg::C_PROG);
      op(11'h258, 32'h0, otp_sec_pkg::C_READ); cmp(rd, 32'hA5A5_FFFF);
      $display("Test locked device done");
      op(11'h000, 32'h1 << otp_sec_pkg::B_MLOCK, otp_sec_pkg::C_PROG_SEC);
      boot();
      op(11'h259, 32'h1, otp_sec_pkg::C_PROG);
      op(11'h259, 32'h0, otp_sec_pkg::C_READ); cmp(rd, 32'h0);
      axr(otp_sec_pkg::OFS_SEC); cmp(rd, sv | 32'h1000);
      $display("Test master lock done");
      close_out();
   end
endmodule : tb
